// ---- design/pct_consts.svh ----
// constants for the print clock position tracker
`ifndef PCT_CONSTS_SVH
`define PCT_CONSTS_SVH
`define PCT_CLK_HZ          32'h017D_7840
`define PCT_CLK_MAX_HZ      32'h0007_A120
`define PCT_MIN_PERIOD_CYC  (`PCT_CLK_HZ / `PCT_CLK_MAX_HZ)
`define PCT_DIST_RST        16'h03E8
`define PCT_PITCH_RST       16'h0082
`define PCT_DIST_MIN        16'h03E8
`define PCT_SRC_CTRL        2'h0
`define PCT_SRC_PRINT       2'h1
`define PCT_SRC_SERVICE     2'h2
`endif

// ---- design/pct_pkg.sv ----
// types of the print clock position tracker
package pct_pkg;
  typedef struct packed {
    logic        valid;
    logic [1:0]  src;
    logic        sel;
    logic [15:0] value;
  } pct_cfg_s;

  typedef enum logic [1:0] {
    PCT_IDLE,
    PCT_DIVIDE,
    PCT_RUN
  } pct_state_e;

  typedef struct packed {
    logic [15:0] dist_nm;
    logic [15:0] pitch;
    logic [31:0] rem;
    logic [15:0] quot;
    logic [4:0]  div_bit;
    logic [15:0] bar_cycles;
    logic [15:0] edge_cnt;
    logic [31:0] position;
    logic [15:0] sub_cyc;
    logic [15:0] period_cyc;
    logic [15:0] interp_nm;
    logic        clk_d;
    logic        trig_d;
    logic        bar_strobe;
    logic        trig_seen;
    logic        cfg_err;
    pct_state_e  state;
  } pct_st_s;
endpackage : pct_pkg

// ---- design/pct_tracker.sv ----
// print clock position tracker: counts tach edges and paces bar strobes
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.svh"
module pct_tracker #(
  parameter int INTERP_EN = 1
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            print_clock,
  input  wire logic            print_trigger,
  input  wire pct_pkg::pct_cfg_s cfg_in,
  output logic                 bar_strobe,
  output logic                 trigger_seen,
  output logic [31:0]          position,
  output logic [15:0]          interp_nm,
  output logic [15:0]          bar_cycles,
  output logic                 cfg_error
);
  pct_pkg::pct_st_s st_ff;
  pct_pkg::pct_st_s nxt_st;

  logic        rise;
  logic        cfg_ok;
  logic [31:0] pitch_nm;
  logic [31:0] trial;
  logic        quot_ovf;

  assign rise     = print_clock & ~st_ff.clk_d;
  assign pitch_nm = 32'(st_ff.pitch) * 32'h0000_2710;
  assign cfg_ok   = cfg_in.valid && (cfg_in.src == `PCT_SRC_CTRL || cfg_in.src == `PCT_SRC_PRINT
                    || cfg_in.src == `PCT_SRC_SERVICE);
  assign trial    = {st_ff.rem[30:0], 1'b0};
  // quotient wider than 16 bits: saturate the spacing rather than wrap
  assign quot_ovf = pitch_nm >= {st_ff.dist_nm, 16'h0000};

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.clk_d      = print_clock;
    nxt_st.trig_d     = print_trigger;
    nxt_st.bar_strobe = 1'b0;
    nxt_st.trig_seen  = print_trigger & ~st_ff.trig_d;
    nxt_st.cfg_err    = 1'b0;
    if (cfg_ok) begin
      if (cfg_in.sel) begin
        nxt_st.pitch = cfg_in.value;
      end else if (cfg_in.value < `PCT_DIST_MIN) begin
        nxt_st.cfg_err = 1'b1;
      end else begin
        nxt_st.dist_nm = cfg_in.value;
      end
      nxt_st.state = pct_pkg::PCT_IDLE;
    end
    if (rise) begin
      nxt_st.position   = st_ff.position + 32'h0000_0001;
      // a stalled tach saturates the period instead of wrapping to zero
      if (st_ff.sub_cyc == 16'hFFFF) begin
        nxt_st.period_cyc = 16'hFFFF;
      end else begin
        nxt_st.period_cyc = st_ff.sub_cyc + 16'h0001;
      end
      nxt_st.sub_cyc    = 16'h0000;
      nxt_st.interp_nm  = 16'h0000;
    end else begin
      if (st_ff.sub_cyc != 16'hFFFF) begin
        nxt_st.sub_cyc = st_ff.sub_cyc + 16'h0001;
      end
      if (INTERP_EN != 0 && st_ff.period_cyc != 16'h0000 && st_ff.sub_cyc < st_ff.period_cyc) begin
        nxt_st.interp_nm = 16'((32'(st_ff.sub_cyc) * 32'(st_ff.dist_nm)) / 32'(st_ff.period_cyc));
      end
    end
    unique case (st_ff.state)
      pct_pkg::PCT_IDLE: begin
        if (!cfg_ok) begin
          nxt_st.rem     = 32'h0000_0000;
          nxt_st.quot    = 16'h0000;
          nxt_st.div_bit = 5'h1F;
          nxt_st.state   = pct_pkg::PCT_DIVIDE;
        end
      end
      pct_pkg::PCT_DIVIDE: begin
        if (!cfg_ok) begin
          if ({trial[31:1], pitch_nm[st_ff.div_bit]} >= 32'(st_ff.dist_nm)) begin
            nxt_st.rem = {trial[31:1], pitch_nm[st_ff.div_bit]} - 32'(st_ff.dist_nm);
            if (st_ff.div_bit < 5'h10) begin
              nxt_st.quot[st_ff.div_bit[3:0]] = 1'b1;
            end
          end else begin
            nxt_st.rem = {trial[31:1], pitch_nm[st_ff.div_bit]};
          end
          if (st_ff.div_bit == 5'h00) begin
            nxt_st.state = pct_pkg::PCT_RUN;
          end else begin
            nxt_st.div_bit = st_ff.div_bit - 5'h01;
          end
        end
      end
      pct_pkg::PCT_RUN: begin
        if (!cfg_ok) begin
          if (quot_ovf) begin
            nxt_st.bar_cycles = 16'hFFFF;
          end else if (st_ff.quot == 16'h0000) begin
            nxt_st.bar_cycles = 16'h0001;
          end else begin
            nxt_st.bar_cycles = st_ff.quot;
          end
          if (rise) begin
            if (st_ff.edge_cnt + 16'h0001 >= st_ff.bar_cycles) begin
              nxt_st.edge_cnt   = 16'h0000;
              nxt_st.bar_strobe = 1'b1;
            end else begin
              nxt_st.edge_cnt = st_ff.edge_cnt + 16'h0001;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff            <= '0;
      st_ff.dist_nm    <= `PCT_DIST_RST;
      st_ff.pitch      <= `PCT_PITCH_RST;
      st_ff.bar_cycles <= 16'h0001;
      st_ff.state      <= pct_pkg::PCT_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bar_strobe   = st_ff.bar_strobe;
  assign trigger_seen = st_ff.trig_seen;
  assign position     = st_ff.position;
  assign interp_nm    = st_ff.interp_nm;
  assign bar_cycles   = st_ff.bar_cycles;
  assign cfg_error    = st_ff.cfg_err;
endmodule : pct_tracker
`default_nettype wire

// ---- sim/pct_sorter_model.sv ----
// sorter-side tach source driving the print clock
`timescale 1ns/1ps
`default_nettype none
module pct_sorter_model (
  input  wire logic clk,
  output var  logic print_clock
);
  initial print_clock = 1'b0;
  task pulses(int n, int half);
    repeat (n) begin
      @(negedge clk) print_clock = 1'b1;
      repeat (half) @(negedge clk);
      print_clock = 1'b0;
      repeat (half - 1) @(negedge clk);
    end
  endtask : pulses
endmodule : pct_sorter_model
`default_nettype wire

// ---- sim/pct_tracker_assertions.sv ----
// assertions for the print clock position tracker
`timescale 1ns/1ps
`default_nettype none
module pct_tracker_assertions (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              print_clock,
  input wire logic              print_trigger,
  input wire pct_pkg::pct_cfg_s cfg_in,
  input wire logic              bar_strobe,
  input wire logic              trigger_seen,
  input wire logic [31:0]       position,
  input wire logic [15:0]       bar_cycles,
  input wire logic              cfg_error
);
  logic pc_d_ff;
  always_ff @(posedge clk) pc_d_ff <= print_clock;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rise;
    print_clock && !pc_d_ff;
  endsequence
  a_edge_counted: assert property (s_rise |=> position == $past(position) + 1) else $error("lost");
  a_pos_hold: assert property (!(print_clock && !pc_d_ff) |=> $stable(position)) else $error("drift");
  a_bar_on_edge: assert property (bar_strobe |-> position != $past(position)) else $error("bar");
  a_bar_pulse: assert property (bar_strobe |=> !bar_strobe) else $error("bar long");
  a_spacing_min: assert property (bar_cycles != 16'h0000) else $error("zero");
  a_dist_refused: assert property (cfg_in.valid && cfg_in.src != 2'h3 && !cfg_in.sel &&
    cfg_in.value < 16'h03E8 |=> cfg_error) else $error("kept");
  a_err_cause: assert property (cfg_error |-> $past(cfg_in.valid && !cfg_in.sel)) else $error("err");
  a_trig_seen: assert property ($rose(print_trigger) |=> trigger_seen) else $error("trig");
endmodule : pct_tracker_assertions
bind pct_tracker pct_tracker_assertions u_chk (.*);
`default_nettype wire

// ---- sim/pct_tracker_tb.sv ----
// self-checking bench for the print clock position tracker
`timescale 1ns/1ps
`default_nettype none
module pct_tracker_tb;
  logic              clk = 0, rst_n = 0, trg = 0, bs, ts, ce, pc;
  pct_pkg::pct_cfg_s cfg = '0;
  logic [31:0]       pos;
  logic [15:0]       bc;
  logic [15:0]       ip;
  int                bad_count = 0, n_compared = 0, nb = 0;
  always #20 clk = ~clk;
  always @(negedge clk) if (bs === 1'b1) nb++;
  pct_sorter_model m (.clk(clk), .print_clock(pc));
  pct_tracker dut (.clk(clk), .rst_n(rst_n), .print_clock(pc), .print_trigger(trg), .cfg_in(cfg), .bar_strobe(bs),
    .trigger_seen(ts), .position(pos), .interp_nm(ip), .bar_cycles(bc), .cfg_error(ce));
  task chk(string s, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %0h got %0h", s, e, g);
    end
  endtask : chk
  task wr(logic [1:0] s, logic l, logic [15:0] v, int w);
    @(negedge clk) cfg <= '{1'b1, s, l, v};
    @(negedge clk) cfg.valid <= 1'b0;
    repeat (w) @(negedge clk);
  endtask : wr
  task t_spacing;
    repeat (40) @(negedge clk);
    chk("bar_cycles", 32'h514, 32'(bc));
    wr(2'h2, 1'b0, 16'h4E20, 0);
    wr(2'h0, 1'b1, 16'h0082, 40);
    chk("bar_cycles", 32'h41, 32'(bc));
    m.pulses(130, 25);
    chk("position", 32'h82, pos);
    chk("interp_nm", 32'h4970, 32'(ip));
    chk("bars", 32'h2, nb);
  endtask : t_spacing
  task t_refuse;
    wr(2'h1, 1'b0, 16'h01F4, 0);
    chk("cfg_error", 32'h1, 32'(ce));
    trg = 1'b1;
    @(negedge clk);
    chk("trigger_seen", 32'h1, 32'(ts));
    @(negedge clk);
    chk("trigger_seen", 32'h0, 32'(ts));
    wr(2'h1, 1'b1, 16'h0104, 0);
    wr(2'h3, 1'b1, 16'h0001, 40);
    chk("bar_cycles", 32'h82, 32'(bc));
  endtask : t_refuse
  task complete_run;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_spacing();
    t_refuse();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule : pct_tracker_tb
`default_nettype wire
